// ---- core/odw_pkg.sv ----
package odw_pkg;

  // ----------------------------------------------------------------
  // Frame layout
  // ----------------------------------------------------------------
  localparam int          FRAME_W    = 32;
  localparam int          CODE_HI    = 19;
  localparam int          CODE_W_DEF = 16;
  localparam int          NUM_CH     = 8;
  localparam logic [5:0]  BIT_LAST   = 6'h1F;
  localparam logic [5:0]  BIT_ZERO   = 6'h00;
  localparam logic [5:0]  BIT_ONE    = 6'h01;

  typedef struct packed {
    logic       zero_bit;
    logic [2:0] dont_care;
    logic [3:0] command;
    logic [3:0] channel_address;
    logic [15:0] code_field;
    logic [3:0] feature;
  } odw_frame_t;

  typedef struct packed {
    logic sclk;
    logic sync_n;
    logic sdin;
  } odw_pins_t;

  // ----------------------------------------------------------------
  // Commands and addresses
  // ----------------------------------------------------------------
  localparam logic [3:0]  CMD_UPD_ONE    = 4'h1;
  localparam logic [3:0]  CMD_WR_UPD_ALL = 4'h2;
  localparam logic [3:0]  CMD_WR_UPD_ONE = 4'h3;
  localparam logic [3:0]  ADDR_BCAST     = 4'hF;
  localparam int          ADDR_TOP_BIT   = 3;

  // ----------------------------------------------------------------
  // Register port map
  // ----------------------------------------------------------------
  localparam int          BUS_AW        = 5;
  localparam int          BUS_DW        = 16;
  localparam logic [1:0]  BANK_INPUT    = 2'h0;
  localparam logic [1:0]  BANK_DAC      = 2'h1;
  localparam logic [4:0]  OFS_CTRL      = 5'h10;
  localparam logic [4:0]  OFS_STAT      = 5'h11;
  localparam int          CTRL_EN_BIT   = 0;
  localparam logic [0:0]  CTRL_RST      = 1'h1;
  localparam int          STAT_BAD_BIT  = 0;
  localparam int          STAT_SHORT_BIT = 1;
  localparam logic [1:0]  STAT_RST      = 2'h0;
  localparam logic [15:0] RDATA_ZERO    = 16'h0000;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,
    ST_SHIFT = 4'h2,
    ST_EXEC  = 4'h4,
    ST_HOLD  = 4'h8
  } odw_state_t;

endpackage : odw_pkg

// ---- core/odw_sync.sv ----
`timescale 1ns/1ps
module odw_sync #(
  parameter int W = 3
) (
  input  wire logic         core_clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);

  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] q_r;
  logic [W-1:0] agree_w;
  logic [W-1:0] q_nxt;

  // A bit moves only once the second and third stage agree
  assign agree_w = ~(s2_r ^ s3_r);
  assign q_nxt   = (s2_r & agree_w) | (q_r & ~agree_w);
  assign q_out   = q_r;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      q_r  <= '0;
    end else begin
      s1_r <= d_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      q_r  <= q_nxt;
    end
  end

endmodule : odw_sync

// ---- core/odw_decoder.sv ----
// Design decisions made here: the register addresses and the plain strobed port.
`timescale 1ns/1ps
module odw_decoder
  import odw_pkg::*;
#(
  parameter int CODE_W = odw_pkg::CODE_W_DEF
) (
  input  wire logic                                          core_clk,
  input  wire logic                                          rst,
  input  wire odw_pkg::odw_pins_t                            serial_pins,
  input  wire logic [odw_pkg::BUS_AW-1:0]                    bus_addr,
  input  wire logic [odw_pkg::BUS_DW-1:0]                    bus_wdata,
  input  wire logic                                          bus_wr,
  input  wire logic                                          bus_rd,
  output logic      [odw_pkg::BUS_DW-1:0]                    bus_rdata,
  output logic      [odw_pkg::NUM_CH-1:0][CODE_W-1:0]        dac_code,
  output logic      [odw_pkg::NUM_CH-1:0]                    dac_load_pulse
);
  import odw_pkg::*;

  // ----------------------------------------------------------------
  // Pin capture
  // ----------------------------------------------------------------
  odw_pins_t pins_q;
  odw_pins_t pins_prev_r;

  odw_sync #(.W(3)) u_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .d_in     (serial_pins),
    .q_out    (pins_q)
  );

  logic sync_fall_w;
  logic sync_rise_w;
  logic sclk_fall_w;

  assign sync_fall_w = pins_prev_r.sync_n & ~pins_q.sync_n;
  assign sync_rise_w = ~pins_prev_r.sync_n & pins_q.sync_n;
  // Data is taken on the falling serial clock, as the host shifts on the rising one
  assign sclk_fall_w = pins_prev_r.sclk & ~pins_q.sclk;

  // ----------------------------------------------------------------
  // Frame sequencer
  // ----------------------------------------------------------------
  odw_state_t           state_r;
  odw_state_t           state_nxt;
  logic [FRAME_W-1:0]   shift_r;
  logic [5:0]           bit_cnt_r;
  logic                 shift_en_w;
  logic                 last_bit_w;

  assign shift_en_w = (state_r == ST_SHIFT) & sclk_fall_w & ~sync_rise_w;
  assign last_bit_w = shift_en_w & (bit_cnt_r == BIT_LAST);

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:  state_nxt = sync_fall_w ? ST_SHIFT : ST_IDLE;
      ST_SHIFT: begin
        if (sync_rise_w) begin
          state_nxt = ST_IDLE;
        end else if (last_bit_w) begin
          state_nxt = ST_EXEC;
        end
      end
      ST_EXEC:  state_nxt = pins_q.sync_n ? ST_IDLE : ST_HOLD;
      ST_HOLD:  state_nxt = pins_q.sync_n ? ST_IDLE : ST_HOLD;
      default:  state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_r     <= ST_IDLE;
      shift_r     <= '0;
      bit_cnt_r   <= BIT_ZERO;
      pins_prev_r <= '0;
    end else begin
      state_r     <= state_nxt;
      pins_prev_r <= pins_q;
      if (sync_fall_w && state_r == ST_IDLE) begin
        bit_cnt_r <= BIT_ZERO;
      end else if (shift_en_w) begin
        bit_cnt_r <= bit_cnt_r + BIT_ONE;
      end
      if (shift_en_w) begin
        shift_r <= {shift_r[FRAME_W-2:0], pins_q.sdin};
      end
    end
  end

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  odw_frame_t          frame_w;
  logic [CODE_W-1:0]   code_w;
  logic [2:0]          ch_idx_w;
  logic                exec_w;
  logic                is_wr_all_w;
  logic                is_wr_one_w;
  logic                is_upd_w;
  logic                addr_single_w;
  logic                addr_bcast_w;
  logic                addr_bad_w;
  logic [NUM_CH-1:0]   ch_onehot_w;
  logic [NUM_CH-1:0]   wr_mask_w;
  logic [NUM_CH-1:0]   upd_mask_w;
  logic [0:0]          ctrl_r;

  // Top bit, don't-care bits and feature bits carry nothing for these commands
  assign frame_w       = odw_frame_t'(shift_r);
  assign code_w        = frame_w.code_field[15 -: CODE_W];
  assign ch_idx_w      = frame_w.channel_address[2:0];
  assign exec_w        = (state_r == ST_EXEC) & ctrl_r[CTRL_EN_BIT];
  assign is_wr_all_w   = frame_w.command == CMD_WR_UPD_ALL;
  assign is_wr_one_w   = frame_w.command == CMD_WR_UPD_ONE;
  assign is_upd_w      = frame_w.command == CMD_UPD_ONE;
  assign addr_bcast_w  = frame_w.channel_address == ADDR_BCAST;
  assign addr_single_w = ~frame_w.channel_address[ADDR_TOP_BIT];
  assign addr_bad_w    = ~addr_single_w & ~addr_bcast_w;
  assign ch_onehot_w   = NUM_CH'(1) << ch_idx_w;

  // Invalid addresses fall through both masks and leave all input and DAC registers alone
  assign wr_mask_w  = ~exec_w ? '0 :
                      ((is_wr_all_w | is_wr_one_w) & addr_bcast_w) ? '1 :
                      ((is_wr_all_w | is_wr_one_w) & addr_single_w) ? ch_onehot_w : '0;
  assign upd_mask_w = ~exec_w ? '0 :
                      ((is_wr_all_w | is_wr_one_w | is_upd_w) & addr_bcast_w) ? '1 :
                      (is_wr_all_w & addr_single_w) ? '1 :
                      ((is_wr_one_w | is_upd_w) & addr_single_w) ? ch_onehot_w : '0;

  // ----------------------------------------------------------------
  // Input and DAC registers
  // ----------------------------------------------------------------
  logic [NUM_CH-1:0][CODE_W-1:0] inp_r;
  logic [NUM_CH-1:0][CODE_W-1:0] dac_r;
  logic [NUM_CH-1:0]             load_r;

  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    logic [CODE_W-1:0] inp_nxt;
    logic [CODE_W-1:0] dac_nxt;
    // New data bypasses the input stage so write and update land in the same edge
    assign inp_nxt = wr_mask_w[i] ? code_w : inp_r[i];
    assign dac_nxt = upd_mask_w[i] ? inp_nxt : dac_r[i];

    always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
        inp_r[i] <= '0;
        dac_r[i] <= '0;
      end else begin
        inp_r[i] <= inp_nxt;
        dac_r[i] <= dac_nxt;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      load_r <= '0;
    end else begin
      load_r <= upd_mask_w;
    end
  end

  assign dac_code       = dac_r;
  assign dac_load_pulse = load_r;

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  logic [1:0]        stat_r;
  logic [1:0]        stat_set_w;
  logic [1:0]        stat_clr_w;
  logic [BUS_DW-1:0] rdata_r;
  logic [BUS_DW-1:0] rd_mux_w;
  logic [BUS_DW-1:0] rd_inp_w;
  logic [BUS_DW-1:0] rd_dac_w;
  logic              wr_ctrl_w;

  assign stat_set_w[STAT_BAD_BIT]   = exec_w & addr_bad_w & (is_wr_all_w | is_wr_one_w | is_upd_w);
  assign stat_set_w[STAT_SHORT_BIT] = (state_r == ST_SHIFT) & sync_rise_w;
  assign stat_clr_w = (bus_wr && bus_addr == OFS_STAT) ? bus_wdata[1:0] : 2'h0;
  assign wr_ctrl_w  = bus_wr && bus_addr == OFS_CTRL;
  assign rd_inp_w   = BUS_DW'(inp_r[bus_addr[2:0]]);
  assign rd_dac_w   = BUS_DW'(dac_r[bus_addr[2:0]]);
  assign rd_mux_w   = ~bus_rd ? RDATA_ZERO :
                      (bus_addr[4:3] == BANK_INPUT) ? rd_inp_w :
                      (bus_addr[4:3] == BANK_DAC) ? rd_dac_w :
                      (bus_addr == OFS_CTRL) ? BUS_DW'(ctrl_r) :
                      (bus_addr == OFS_STAT) ? BUS_DW'(stat_r) : RDATA_ZERO;
  assign bus_rdata  = rdata_r;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctrl_r  <= CTRL_RST;
      stat_r  <= STAT_RST;
      rdata_r <= RDATA_ZERO;
    end else begin
      rdata_r <= rd_mux_w;
      // A new event outranks a clear in the same cycle
      stat_r  <= (stat_r & ~stat_clr_w) | stat_set_w;
      if (wr_ctrl_w) begin
        ctrl_r <= bus_wdata[0:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_exec_after_full: assert property (state_r == ST_EXEC |-> $past(bit_cnt_r) == BIT_LAST)
    else $error("frame executed before 32 bits");
  a_short_no_change: assert property (state_r == ST_SHIFT && sync_rise_w |=>
      state_r == ST_IDLE && $stable(inp_r) && $stable(dac_r))
    else $error("short frame changed a register");
  a_bad_addr_hold: assert property (exec_w && addr_bad_w |=>
      $stable(inp_r) && $stable(dac_r))
    else $error("invalid address changed a register");
  a_bcast_write_all: assert property (exec_w && (is_wr_all_w || is_wr_one_w) &&
      addr_bcast_w |=> inp_r == {NUM_CH{$past(code_w)}} && dac_r == inp_r && load_r == '1)
    else $error("broadcast did not reach all channels");
  a_single_code_pos: assert property (exec_w && is_wr_one_w && addr_single_w |=>
      inp_r[$past(ch_idx_w)] == $past(shift_r[CODE_HI -: CODE_W]))
    else $error("code taken from wrong frame bits");
  a_wr_upd_all: assert property (exec_w && is_wr_all_w && addr_single_w |=>
      dac_r == inp_r && load_r == '1)
    else $error("write with update all did not copy all");
  a_wr_upd_one: assert property (exec_w && is_wr_one_w && addr_single_w |=>
      load_r == $past(ch_onehot_w) && dac_r[$past(ch_idx_w)] == $past(code_w))
    else $error("single update touched wrong channel");
  a_update_no_write: assert property (exec_w && is_upd_w && addr_single_w |=>
      $stable(inp_r) && dac_r[$past(ch_idx_w)] == inp_r[$past(ch_idx_w)])
    else $error("update command altered an input register");
  a_read_one_cycle: assert property (!$past(bus_rd) |-> bus_rdata == RDATA_ZERO)
    else $error("read data outside its cycle");

  c_bcast: cover property (exec_w && is_wr_one_w && addr_bcast_w);
  c_short_frame: cover property (state_r == ST_SHIFT && sync_rise_w);
  c_update_one: cover property (exec_w && is_upd_w && addr_single_w);
  c_bad_addr: cover property (exec_w && addr_bad_w && is_wr_all_w);

endmodule : odw_decoder

// ---- test/odw_host_model.sv ----
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Serial host: sclk parks high outside frames, sdin flips when idle
// ----------------------------------------------------------------
module odw_host_model (
  output odw_pkg::odw_pins_t pins
);
  import odw_pkg::*;

  initial pins = '{sclk: 1'b1, sync_n: 1'b1, sdin: 1'b0};

  // Half periods of 4 core clocks keep well clear of the pin filter
  task automatic send_frame(input logic [31:0] frame, input int nbits);
    // Keeps every pin change clear of a core clock edge
    #3;
    pins.sync_n = 1'b0;
    #80;
    for (int i = 0; i < nbits; i++) begin
      pins.sdin = frame[31 - i];
      #40 pins.sclk = 1'b0;
      #40 pins.sclk = 1'b1;
    end
    #40 pins.sync_n = 1'b1;
    // Idle data shows the inverse of the last bit, never a stale copy
    pins.sdin = ~pins.sdin;
    #100;
  endtask : send_frame
endmodule : odw_host_model

// ---- test/tb_octal_dac_write_decoder.sv ----
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin miscompares++; \
  $display("Error %s expected %h seen %h", nm, ex, got); end end
module tb_octal_dac_write_decoder;
  import odw_pkg::*;

  logic                    core_clk   = 1'b0;
  logic                    rst        = 1'b1;
  odw_pins_t               pins;
  logic [BUS_AW-1:0]       bus_addr   = 5'h00;
  logic [BUS_DW-1:0]       bus_wdata  = 16'h0000;
  logic [BUS_DW-1:0]       bus_rdata;
  logic                    bus_wr     = 1'b0;
  logic                    bus_rd     = 1'b0;
  logic [NUM_CH-1:0][15:0] dac_code;
  logic [NUM_CH-1:0]       dac_load_pulse;
  logic [NUM_CH-1:0][11:0] dac_code_nar;
  logic [NUM_CH-1:0]       seen;
  logic [15:0]             inp_m [NUM_CH];
  logic [15:0]             dac_m [NUM_CH];
  logic                    en_m       = 1'b1;
  int                      miscompares = 0;
  int                      comparisons = 0;

  always #5 core_clk = ~core_clk;

  odw_host_model odw_host_model_inst (.pins(pins));

  odw_decoder #(.CODE_W(16)) odw_decoder_inst (
    .core_clk       (core_clk),
    .rst            (rst),
    .serial_pins    (pins),
    .bus_addr       (bus_addr),
    .bus_wdata      (bus_wdata),
    .bus_wr         (bus_wr),
    .bus_rd         (bus_rd),
    .bus_rdata      (bus_rdata),
    .dac_code       (dac_code),
    .dac_load_pulse (dac_load_pulse)
  );

  // Narrow variant on the same pins and bus; its code sits in frame bits 19 to 8
  if (1) begin : g_narrow
    odw_decoder #(.CODE_W(12)) odw_decoder_inst (
      .core_clk       (core_clk),
      .rst            (rst),
      .serial_pins    (pins),
      .bus_addr       (bus_addr),
      .bus_wdata      (bus_wdata),
      .bus_wr         (bus_wr),
      .bus_rd         (bus_rd),
      .bus_rdata      (),
      .dac_code       (dac_code_nar),
      .dac_load_pulse ()
    );
  end

  // ----------------------------------------------------------------
  // Bus and frame tasks
  // ----------------------------------------------------------------
  task automatic final_report();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : final_report

  task automatic bus_write(input logic [4:0] a, input logic [15:0] d);
    @(posedge core_clk);
    bus_addr  <= a;
    bus_wdata <= d;
    bus_wr    <= 1'b1;
    @(posedge core_clk);
    bus_wr    <= 1'b0;
  endtask : bus_write

  task automatic bus_read(input logic [4:0] a, input logic [15:0] ex, input string nm);
    @(posedge core_clk);
    bus_addr <= a;
    bus_rd   <= 1'b1;
    @(posedge core_clk);
    bus_rd   <= 1'b0;
    #1 `CHK(nm, ex, bus_rdata)
  endtask : bus_read

  task automatic check_all();
    for (int i = 0; i < NUM_CH; i++) begin
      `CHK("dac_code", dac_m[i], dac_code[i])
      `CHK("narrow dac_code", dac_m[i][15:4], dac_code_nar[i])
      bus_read({BANK_INPUT, 3'(i)}, inp_m[i], "input reg");
      bus_read({BANK_DAC, 3'(i)}, dac_m[i], "dac reg");
    end
  endtask : check_all

  // Model update first, so expectations never come from the outputs
  task automatic frame(input logic [3:0] cmd, input logic [3:0] a, input logic [15:0] d,
                       input int n);
    logic [7:0] m;
    logic       act;
    odw_frame_t f;
    m   = 8'h00;
    act = (n == 32) && en_m;
    f   = '{zero_bit: 1'b0, dont_care: 3'h7, command: cmd, channel_address: a,
            code_field: d, feature: 4'hF};
    if (act && (cmd == CMD_WR_UPD_ONE || cmd == CMD_WR_UPD_ALL)) begin
      if (!a[3]) inp_m[a[2:0]] = d;
      if (a == ADDR_BCAST) for (int i = 0; i < NUM_CH; i++) inp_m[i] = d;
    end
    if (act && cmd inside {CMD_UPD_ONE, CMD_WR_UPD_ALL, CMD_WR_UPD_ONE}) begin
      if (a == ADDR_BCAST || (cmd == CMD_WR_UPD_ALL && !a[3])) m = 8'hFF;
      else if (!a[3]) m = 8'h01 << a[2:0];
    end
    for (int i = 0; i < NUM_CH; i++) if (m[i]) dac_m[i] = inp_m[i];
    fork
      odw_host_model_inst.send_frame(f, n);
      begin
        seen = 8'h00;
        repeat (320) begin
          @(posedge core_clk);
          #1 seen = seen | dac_load_pulse;
        end
      end
    join
    `CHK("load pulses", m, seen)
    check_all();
  endtask : frame

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    #500000;
    miscompares++;
    final_report();
  end

  initial begin
    for (int i = 0; i < NUM_CH; i++) begin
      inp_m[i] = 16'h0000;
      dac_m[i] = 16'h0000;
    end
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    repeat (10) @(posedge core_clk);
    check_all();
    bus_read(OFS_CTRL, 16'h0001, "ctrl");
    bus_read(OFS_STAT, 16'h0000, "stat");
    for (int c = 0; c < NUM_CH; c++)
      frame(CMD_WR_UPD_ONE, 4'(c), 16'h8001 ^ (16'h1111 * 16'(c)), 32);
    frame(CMD_WR_UPD_ALL, 4'h2, 16'h7FFE, 32);
    frame(CMD_WR_UPD_ALL, 4'h7, 16'h0010, 32);
    frame(CMD_UPD_ONE, 4'h5, 16'hFFFF, 32);
    frame(CMD_WR_UPD_ONE, 4'h8, 16'h1357, 32);
    frame(CMD_WR_UPD_ALL, 4'hE, 16'h2468, 32);
    bus_read(OFS_STAT, 16'h0001, "stat invalid");
    bus_write(OFS_STAT, 16'h0003);
    bus_read(OFS_STAT, 16'h0000, "stat cleared");
    frame(CMD_WR_UPD_ONE, ADDR_BCAST, 16'hC3A5, 32);
    frame(CMD_WR_UPD_ALL, ADDR_BCAST, 16'h5A3C, 32);
    frame(CMD_WR_UPD_ONE, 4'h1, 16'h0F0F, 20);
    bus_read(OFS_STAT, 16'h0002, "stat short");
    frame(4'h0, 4'h3, 16'h1234, 32);
    bus_write(OFS_CTRL, 16'h0000);
    en_m = 1'b0;
    frame(CMD_WR_UPD_ONE, 4'h4, 16'hBEEF, 32);
    bus_write(OFS_CTRL, 16'h0001);
    en_m = 1'b1;
    frame(CMD_WR_UPD_ONE, 4'h4, 16'hBEEF, 32);
    bus_write(5'h05, 16'hFFFF);
    bus_read(5'h12, 16'h0000, "unmapped");
    check_all();
    final_report();
  end
endmodule : tb_octal_dac_write_decoder
